/* hw/tce_event_regs.sv */
// module: partner-kind register and event flag register of the cc controller
//
// Operation
// - partner kind bit 4 shows sink
// - partner kind bit 3 shows source
// - partner kind bit 1 shows debug accessory
// - partner kind bit 0 shows audio accessory
// - flag bit 3 on accessory change
// - flag bit 2 on current code change
// - flag bit 1 on detach
// - flag bit 0 on attach, kind shown
// - event flags at 13h, bits 7:4 reserved
// - per-event masks block host signalling
// - global mask blocks all signalling
// - current code encodes ra, default, 1.5, 3 a
`timescale 1ns/1ps
module tce_event_regs (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // results of the cc detection state machine, same clock
  input  wire logic       attached,
  input  wire logic       acc_present,
  input  wire logic       sink_found,
  input  wire logic       source_found,
  input  wire logic       debug_accessory_found,
  input  wire logic       audio_accessory_found,
  input  wire logic [1:0] advertised_current_code,
  // mask bits from the neighbouring mask and control registers
  input  wire logic       attach_mask,
  input  wire logic       detach_mask,
  input  wire logic       current_level_change_mask,
  input  wire logic       accessory_change_mask,
  input  wire logic       global_mask,
  // register port from the serial interface engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // host alert line, low while an unmasked event is pending and global_mask is clear
  output logic            host_alert_n
);

  tce_flag_if fl ();

  logic [7:0] partner_kind;
  logic       prev_attached;
  logic       prev_acc_present;
  logic [1:0] prev_code;
  logic [7:0] next_partner_kind;
  logic [3:0] event_mask;
  logic [3:0] pending;
  logic       rise_attach;
  logic       fall_attach;
  logic       acc_resolved;
  logic       level_change;
  logic       wr_flags;
  tce_pkg::tce_cur_code_t cur_code;

  // decode the measured current advertisement
  assign cur_code = tce_pkg::tce_cur_code_t'(advertised_current_code);

  // previous values of the detection results, for edge detection
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_attached    <= 1'b0;
      prev_acc_present <= 1'b0;
      prev_code        <= tce_pkg::TCE_CUR_NONE;
    end else begin
      prev_attached    <= attached;
      prev_acc_present <= acc_present;
      prev_code        <= cur_code;
    end
  end

  // event conditions taken from the detection results
  assign rise_attach  = attached && !prev_attached;
  assign fall_attach  = !attached && prev_attached;
  assign acc_resolved = prev_acc_present &&
                        (debug_accessory_found || audio_accessory_found);
  assign level_change = cur_code != prev_code;

  // partner kind follows the detection only while attached
  always_comb begin
    next_partner_kind = tce_pkg::KIND_RESET;
    if (attached) begin
      next_partner_kind[tce_pkg::KIND_SINK]   = sink_found;
      next_partner_kind[tce_pkg::KIND_SOURCE] = source_found;
      next_partner_kind[tce_pkg::KIND_DEBUG]  = debug_accessory_found;
      next_partner_kind[tce_pkg::KIND_AUDIO]  = audio_accessory_found;
    end
  end

  // partner kind register, read-only to software
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      partner_kind <= tce_pkg::KIND_RESET;
    end else begin
      partner_kind <= next_partner_kind;
    end
  end

  // event sets and software clears into the flag bank
  assign wr_flags = reg_wr && (reg_addr == tce_pkg::ADDR_EVENT_FLAGS);
  always_comb begin
    fl.set = '0;
    fl.set[tce_pkg::FLAG_ACC_CH]  = acc_resolved;
    fl.set[tce_pkg::FLAG_LEVEL]   = level_change;
    fl.set[tce_pkg::FLAG_DETACH]  = fall_attach;
    fl.set[tce_pkg::FLAG_ATTACH]  = rise_attach;
    fl.clr = wr_flags ? reg_wdata[tce_pkg::FLAG_COUNT-1:0] : '0;
  end

  tce_flag_bank u_flags (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .fl      (fl)
  );

  // per-event masks, ordered as the flag bits
  always_comb begin
    event_mask = '0;
    event_mask[tce_pkg::FLAG_ACC_CH] = accessory_change_mask;
    event_mask[tce_pkg::FLAG_LEVEL]  = current_level_change_mask;
    event_mask[tce_pkg::FLAG_DETACH] = detach_mask;
    event_mask[tce_pkg::FLAG_ATTACH] = attach_mask;
  end
  assign pending = fl.flags & ~event_mask;

  // alert line to the host processor
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      host_alert_n <= 1'b1;
    end else begin
      host_alert_n <= !((|pending) && !global_mask);
    end
  end

  // register read: data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= tce_pkg::READ_UNMAPPED;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tce_pkg::ADDR_PARTNER_KIND: reg_rdata <= partner_kind;
        tce_pkg::ADDR_EVENT_FLAGS:  reg_rdata <= {4'h0, fl.flags};
        default:                    reg_rdata <= tce_pkg::READ_UNMAPPED;
      endcase
    end
  end

  // read answer strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // checks on the design's own behaviour

  sequence s_attach_edge;
    !attached ##1 attached;
  endsequence

  sequence s_detach_edge;
    attached ##1 !attached;
  endsequence

  sequence s_kind_read;
    reg_rd && reg_addr == tce_pkg::ADDR_PARTNER_KIND;
  endsequence

  sequence s_flag_read;
    reg_rd && reg_addr == tce_pkg::ADDR_EVENT_FLAGS;
  endsequence

  a_sink_kind_bit: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    attached && sink_found |=> partner_kind[tce_pkg::KIND_SINK])
    else $error("sink bit not set for attached sink");

  a_source_kind_bit: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    attached |=> partner_kind[tce_pkg::KIND_SOURCE] == $past(source_found))
    else $error("source bit does not follow detection");

  a_debug_kind_bit: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    attached |=> partner_kind[tce_pkg::KIND_DEBUG] ==
                 $past(debug_accessory_found))
    else $error("debug accessory bit does not follow detection");

  a_audio_kind_bit: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    attached |=> partner_kind[tce_pkg::KIND_AUDIO] ==
                 $past(audio_accessory_found))
    else $error("audio accessory bit does not follow detection");

  a_kind_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_kind_read |=> reg_rvalid && reg_rdata[7:5] == 3'h0 &&
                    !reg_rdata[2] && reg_rdata == $past(partner_kind))
    else $error("partner kind read wrong or reserved bits set");

  a_acc_change_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    acc_present ##1 (debug_accessory_found || audio_accessory_found)
    |=> fl.flags[tce_pkg::FLAG_ACC_CH])
    else $error("accessory change not flagged");

  a_level_change_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !$stable(advertised_current_code)
    |=> fl.flags[tce_pkg::FLAG_LEVEL])
    else $error("current level change not flagged");

  a_detach_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_detach_edge |=> fl.flags[tce_pkg::FLAG_DETACH])
    else $error("detach not flagged");

  a_attach_flag_kind: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_attach_edge |=> fl.flags[tce_pkg::FLAG_ATTACH] &&
                      partner_kind == $past(next_partner_kind))
    else $error("attach not flagged or kind not shown");

  a_flags_read_back: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_flag_read |=> reg_rdata == {4'h0, $past(fl.flags)})
    else $error("event flag read wrong");

  a_masked_no_alert: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (fl.flags & ~event_mask) == 4'h0 |=> host_alert_n)
    else $error("alert raised by masked events");

  a_unmasked_alert: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (|(fl.flags & ~event_mask)) && !global_mask |=> !host_alert_n)
    else $error("unmasked event did not alert");

  a_global_mask_quiet: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    global_mask [*2] |-> host_alert_n)
    else $error("alert raised under global mask");

  a_code_legal: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    cur_code == tce_pkg::TCE_CUR_NONE |=> prev_code == 2'h0)
    else $error("current code not held as decoded");

  a_w1c_clears: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wr_flags && reg_wdata[tce_pkg::FLAG_ATTACH] && !rise_attach
    |=> !fl.flags[tce_pkg::FLAG_ATTACH])
    else $error("write one did not clear attach flag");

  a_w0_keeps: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wr_flags && !reg_wdata[tce_pkg::FLAG_ATTACH] &&
    fl.flags[tce_pkg::FLAG_ATTACH] |=> fl.flags[tce_pkg::FLAG_ATTACH])
    else $error("write zero cleared attach flag");

  a_unattached_no_kind: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_detach_edge ##1 !attached |-> partner_kind == 8'h00)
    else $error("partner kind kept while unattached");

  // reads of addresses outside the map
  sequence s_other_read;
    reg_rd && reg_addr != tce_pkg::ADDR_PARTNER_KIND &&
    reg_addr != tce_pkg::ADDR_EVENT_FLAGS;
  endsequence

  a_read_answer: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    reg_rvalid == $past(reg_rd))
    else $error("read answer strobe out of step");

  a_unmapped_reads_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    s_other_read |=> reg_rvalid && reg_rdata == tce_pkg::READ_UNMAPPED)
    else $error("unmapped address read not zero");

  a_kind_clear_detached: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !attached |=> partner_kind == tce_pkg::KIND_RESET)
    else $error("partner kind shown while unattached");

  a_kind_write_ignored: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    reg_wr && reg_addr == tce_pkg::ADDR_PARTNER_KIND
    |=> partner_kind == $past(next_partner_kind))
    else $error("write reached partner kind");

endmodule : tce_event_regs

/* hw/tce_pkg.sv */
// package: register map, field positions and encodings of the event block
package tce_pkg;

  // register addresses on the serial register port
  localparam logic [7:0] ADDR_PARTNER_KIND = 8'h12;
  localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h13;

  // partner_kind field positions
  localparam int KIND_SINK   = 4;
  localparam int KIND_SOURCE = 3;
  localparam int KIND_DEBUG  = 1;
  localparam int KIND_AUDIO  = 0;

  // event_flags field positions
  localparam int FLAG_ACC_CH  = 3;
  localparam int FLAG_LEVEL   = 2;
  localparam int FLAG_DETACH  = 1;
  localparam int FLAG_ATTACH  = 0;
  localparam int FLAG_COUNT   = 4;

  // reset values
  localparam logic [7:0] KIND_RESET  = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // advertised current code on the configuration channel
  typedef enum logic [1:0] {
    TCE_CUR_NONE    = 2'h0, // ra or unattached sink
    TCE_CUR_DEFAULT = 2'h1, // default usb current
    TCE_CUR_1A5     = 2'h2, // 1.5 a
    TCE_CUR_3A      = 2'h3  // 3 a
  } tce_cur_code_t;

endpackage : tce_pkg

/* hw/tce_flag_if.sv */
// interface: set, clear and state of the sticky event flags
`timescale 1ns/1ps
interface tce_flag_if;
  logic [tce_pkg::FLAG_COUNT-1:0] set;
  logic [tce_pkg::FLAG_COUNT-1:0] clr;
  logic [tce_pkg::FLAG_COUNT-1:0] flags;

  modport owner (input set, input clr, output flags);
  modport user  (output set, output clr, input flags);
endinterface : tce_flag_if

/* hw/tce_flag_bank.sv */
// module: sticky event flags, write one to clear, set beats clear
`timescale 1ns/1ps
module tce_flag_bank (
  input wire logic    clk_sys,
  input wire logic    resetn,
  tce_flag_if.owner   fl
);

  // one sticky flag per event
  genvar i;
  generate
    for (i = 0; i < tce_pkg::FLAG_COUNT; i++) begin : g_flag
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          fl.flags[i] <= tce_pkg::FLAGS_RESET[i];
        end else if (fl.set[i]) begin
          fl.flags[i] <= 1'b1;
        end else if (fl.clr[i]) begin
          fl.flags[i] <= 1'b0;
        end
      end

      a_set_wins_clear: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        fl.set[i] |=> fl.flags[i])
        else $error("event flag lost on set");

      a_flag_holds_idle: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (!fl.set[i] && !fl.clr[i]) |=> fl.flags[i] == $past(fl.flags[i]))
        else $error("event flag changed without cause");
    end
  endgenerate

endmodule : tce_flag_bank

/* sim/tce_partner_model.sv */
// partner model: cc detection results for a chosen partner kind
`timescale 1ns/1ps
module tce_partner_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] kind_sel,
  input  wire logic [1:0] cur_sel,
  output logic            attached,
  output logic            acc_present,
  output logic            sink_found,
  output logic            source_found,
  output logic            debug_accessory_found,
  output logic            audio_accessory_found,
  output logic      [1:0] advertised_current_code
);
  logic acc_sel;

  // kind 1 sink, 2 source, 3 debug, 4 audio, 0 nothing attached
  assign acc_sel = (kind_sel == 3'h3) || (kind_sel == 3'h4);

  // quiet port until the bench picks a partner
  initial begin
    {attached, acc_present, sink_found, source_found} = 4'h0;
    {debug_accessory_found, audio_accessory_found} = 2'h0;
    advertised_current_code = 2'h0;
  end

  // accessories show one cycle of accessory present before attaching
  always @(posedge clk_sys) begin
    acc_present <= acc_sel && !attached && !acc_present;
    attached <= kind_sel != 3'h0 && (!acc_sel || acc_present || attached);
    sink_found <= kind_sel == 3'h1;
    source_found <= kind_sel == 3'h2;
    debug_accessory_found <= kind_sel == 3'h3 && (acc_present || attached);
    audio_accessory_found <= kind_sel == 3'h4 && (acc_present || attached);
    advertised_current_code <= (kind_sel == 3'h1 || kind_sel == 3'h2) ?
                               cur_sel : 2'h0;
  end
endmodule : tce_partner_model

/* sim/tb.sv */
// testbench: attach, detach, level change and flag clearing of the block
`timescale 1ns/1ps
module tb;
  logic       clk_sys, resetn, reg_wr, reg_rd, reg_rvalid, host_alert_n;
  logic       attached, acc_present, sink_found, source_found;
  logic       debug_accessory_found, audio_accessory_found, global_mask;
  logic [1:0] advertised_current_code, cur_sel, cur2;
  logic [2:0] kind_sel;
  logic [3:0] mask;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, exp_flags;
  integer     seed, errors, tests_run, k;

  tce_event_regs DUT (.clk_sys(clk_sys), .resetn(resetn),
    .attached(attached), .acc_present(acc_present),
    .sink_found(sink_found), .source_found(source_found),
    .debug_accessory_found(debug_accessory_found),
    .audio_accessory_found(audio_accessory_found),
    .advertised_current_code(advertised_current_code),
    .attach_mask(mask[0]), .detach_mask(mask[1]),
    .current_level_change_mask(mask[2]),
    .accessory_change_mask(mask[3]), .global_mask(global_mask),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .host_alert_n(host_alert_n));

  tce_partner_model u_partner (.clk_sys(clk_sys), .kind_sel(kind_sel),
    .cur_sel(cur_sel), .attached(attached), .acc_present(acc_present),
    .sink_found(sink_found), .source_found(source_found),
    .debug_accessory_found(debug_accessory_found),
    .audio_accessory_found(audio_accessory_found),
    .advertised_current_code(advertised_current_code));

  // 250 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task check(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  // one-cycle read strobe, answer sampled in the following cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("rvalid", {7'h0, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask : rd

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  function automatic logic [7:0] exp_kind(input int n);
    logic [7:0] e;
    e = 8'h00;
    case (n)
      1: e[tce_pkg::KIND_SINK] = 1'b1;
      2: e[tce_pkg::KIND_SOURCE] = 1'b1;
      3: e[tce_pkg::KIND_DEBUG] = 1'b1;
      4: e[tce_pkg::KIND_AUDIO] = 1'b1;
      default: e = 8'h00;
    endcase
    return e;
  endfunction : exp_kind

  // alert stays high unless an unmasked flag is pending with the global mask clear
  function automatic logic exp_alert(input logic [3:0] f, m, input logic g);
    return g || !(|(f & ~m));
  endfunction : exp_alert

  // watchdog cuts a hang short
  initial begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    end_of_test;
  end

  // main sequence: every partner kind attaches and detaches once
  initial begin
    seed = 27369;
    errors = 0;
    tests_run = 0;
    {resetn, reg_wr, reg_rd, global_mask} = 4'h0;
    {reg_addr, reg_wdata, kind_sel, cur_sel, mask} = 25'h0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h20, rd_val);
    check("unmapped", rd_val, tce_pkg::READ_UNMAPPED);
    rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
    check("flags reset", rd_val, 8'h00);
    for (k = 1; k <= 4; k++) begin
      @(posedge clk_sys);
      cur2 = 2'($random(seed));
      cur_sel <= cur2;
      mask <= 4'($random(seed));
      global_mask <= (k == 3);
      kind_sel <= 3'(k);
      repeat (5) @(posedge clk_sys);
      rd(tce_pkg::ADDR_PARTNER_KIND, rd_val);
      check("kind", rd_val, exp_kind(k));
      exp_flags = 8'h01 | ((k < 3 && cur2 != 2'h0) ? 8'h04 : 8'h00) |
                  ((k > 2) ? 8'h08 : 8'h00);
      rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
      check("flags", rd_val, exp_flags);
      check("alert", {7'h0, host_alert_n},
            {7'h0, exp_alert(exp_flags[3:0], mask, global_mask)});
      wr(tce_pkg::ADDR_PARTNER_KIND, 8'hFF);
      wr(tce_pkg::ADDR_EVENT_FLAGS, 8'h00);
      rd(tce_pkg::ADDR_PARTNER_KIND, rd_val);
      check("kind ro", rd_val, exp_kind(k));
      rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
      check("write zero", rd_val, exp_flags);
      wr(tce_pkg::ADDR_EVENT_FLAGS, 8'hFF);
      rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
      check("cleared", rd_val, 8'h00);
      check("alert idle", {7'h0, host_alert_n}, 8'h01);
      if (k < 3) begin
        @(posedge clk_sys);
        cur_sel <= cur2 + 2'h1;
        repeat (4) @(posedge clk_sys);
        rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
        check("level", rd_val, 8'h04);
      end
      @(posedge clk_sys);
      kind_sel <= 3'h0;
      repeat (4) @(posedge clk_sys);
      rd(tce_pkg::ADDR_PARTNER_KIND, rd_val);
      check("kind gone", rd_val, 8'h00);
      rd(tce_pkg::ADDR_EVENT_FLAGS, rd_val);
      check("detach", rd_val, (k < 3) ? 8'h06 : 8'h02);
      wr(tce_pkg::ADDR_EVENT_FLAGS, 8'hFF);
    end
    end_of_test;
  end
endmodule : tb
